//--- verilog/isp_programming_cmd_port.sv
/* Four-byte serial instruction port and JTAG port decoded into one-cycle
   flash/EEPROM requests, plus the fuse and lock bytes and the core reset.
   Assumes slow asynchronous pins and read data two clocks after a request. */
// Implementation choices: the address-and-strobe port.
// Functional notes
// - Instructions are four bytes; AC 53 00 00 enables programming first.
// - AC 80 erases program memory and EEPROM.
// - F0 poll returns busy in bit 0 of the fourth byte.
// - 4D stores byte three as extended high address.
// - 48 and 40 load high and low data bytes into the flash page.
// - C1 loads an EEPROM page byte; C2 writes the EEPROM page.
// - 28 and 20 return high or low program word byte in byte four.
// - 4C writes the loaded flash page at the given address.
// - AC with E0, A0, A8, A4 writes lock, low, high, extended fuse.
// - 50/00, 58/08, 50/08 read low, high, extended fuse bytes.
// - Fuse and lock bits: zero is programmed, one unprogrammed.
// - JTAG registers shift least significant bit first in and out.
// - Disable bit clears two clocks after external reset goes low.
// - JTAG instruction register is four bits wide.
// - Opcode C selects a one-bit reset register holding the core reset.
// - Opcode 4 selects 16-bit unlock register checked at Update-DR.
// - Opcode 5 selects 15-bit command register capturing previous result.
// - Update-DR with command opcode presents the command to flash.
// - Each Run-Test/Idle pass with command opcode gives one command clock.
// - Unlock signature is A370; unlock clears on reset and on leaving.
// - Serial data sampled on clock rise, driven on clock fall.
// - Second byte echoes while the third byte is received.
`timescale 1ns/1ps

module isp_programming_cmd_port (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ext_reset_n,
  input  wire logic        serial_clk,
  input  wire logic        serial_prog_data_in,
  output logic             serial_prog_data_out,
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  output logic             tdo,
  input  wire logic        jtag_enable_fuse,
  input  wire logic        jtd_write,
  input  wire logic        jtd_wdata,
  output logic             jtag_disable_bit,
  output logic             core_reset,
  output logic             serial_prog_mode,
  output logic             jtag_prog_mode,
  output logic             nvm_start,
  output logic [3:0]       nvm_op,
  output logic [23:0]      nvm_addr,
  output logic [7:0]       nvm_wdata,
  input  wire logic        nvm_busy,
  input  wire logic [7:0]  nvm_rdata,
  output logic [14:0]      jtag_cmd,
  output logic             jtag_cmd_clk,
  input  wire logic [14:0] jtag_cmd_result,
  output logic [7:0]       fuse_low,
  output logic [7:0]       fuse_high,
  output logic [7:0]       fuse_ext,
  output logic [7:0]       lock_bits
);
  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001, TAP_IDLE = 16'h0002, TAP_SEL_DR = 16'h0004, TAP_CAP_DR = 16'h0008,
    TAP_SHIFT_DR = 16'h0010, TAP_EXIT1_DR = 16'h0020, TAP_PAUSE_DR = 16'h0040,
    TAP_EXIT2_DR = 16'h0080, TAP_UPDATE_DR = 16'h0100, TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400, TAP_SHIFT_IR = 16'h0800, TAP_EXIT1_IR = 16'h1000,
    TAP_PAUSE_IR = 16'h2000, TAP_EXIT2_IR = 16'h4000, TAP_UPDATE_IR = 16'h8000
  } tap_state_type;
  // Pin synchronisers: first stage feeds only the second
  logic [5:0] pins_raw;
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic       sclk_d;
  logic       tck_d;

  assign pins_raw = {ext_reset_n, serial_clk, serial_prog_data_in, tck, tms, tdi};

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_sync
      always_ff @(posedge clock) begin
        if (rst) begin
          sync1[g] <= isp_pkg::SYNC_RESET[g];
          sync2[g] <= isp_pkg::SYNC_RESET[g];
        end else begin
          sync1[g] <= pins_raw[g];
          sync2[g] <= sync1[g];
        end
      end
    end
  endgenerate

  wire rstn_s = sync2[5];
  wire sclk_s = sync2[4];
  wire sdi_s  = sync2[3];
  wire tck_s  = sync2[2];
  wire tms_s  = sync2[1];
  wire tdi_s  = sync2[0];
  wire in_isp = ~rstn_s;

  always_ff @(posedge clock) begin
    if (rst) begin
      sclk_d <= 1'b0;
      tck_d  <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
      tck_d  <= tck_s;
    end
  end

  wire s_rise = sclk_s & ~sclk_d;
  wire s_fall = ~sclk_s & sclk_d;
  wire t_rise = tck_s & ~tck_d;
  wire t_fall = ~tck_s & tck_d;

  // Serial instruction port
  logic [4:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] byte1;
  logic [7:0] byte2;
  logic [7:0] byte3;
  logic [7:0] out_sr;
  logic [7:0] ext_addr;
  logic [1:0] rd_wait;

  wire [7:0] next_in   = {shift_in[6:0], sdi_s};
  wire       byte_done = s_rise & (bit_cnt[2:0] == 3'h7);
  wire       done_b2   = byte_done & (bit_cnt[4:3] == 2'h1);
  wire       done_b3   = byte_done & (bit_cnt[4:3] == 2'h2);
  wire       done_b4   = byte_done & (bit_cnt[4:3] == 2'h3);
  wire       is_ac     = byte1 == isp_pkg::SER_PREFIX_AC;
  wire       cmd_en    = is_ac & (byte2 == isp_pkg::SER_ENABLE_B2);
  wire       armed     = serial_prog_mode;
  wire       rd_a      = byte1 == isp_pkg::SER_FUSE_RD_A;
  wire       rd_b      = byte1 == isp_pkg::SER_FUSE_RD_B;
  wire       sel0      = byte2 == isp_pkg::SER_FUSE_SEL_0;
  wire       sel8      = byte2 == isp_pkg::SER_FUSE_SEL_8;
  wire       q_poll    = byte1 == isp_pkg::SER_POLL;
  wire       q_mem_rd  = (byte1 == isp_pkg::SER_READ_HI) | (byte1 == isp_pkg::SER_READ_LO)
                       | (byte1 == isp_pkg::SER_EE_READ);
  wire       q_local   = q_poll | ((rd_a | rd_b) & (sel0 | sel8));
  // Answers kept on chip; 58/00 reads the lock byte
  wire [7:0] local_reply = q_poll ? {7'h00, nvm_busy} :
    (rd_a & sel0) ? fuse_low :
    (rd_b & sel8) ? fuse_high :
    (rd_a & sel8) ? fuse_ext :
    (rd_b & sel0) ? lock_bits : 8'h00;
  // Requests to the memory controller
  logic        next_start;
  logic [3:0]  next_op;
  logic [23:0] next_addr;
  logic [7:0]  next_wdata;
  wire  [23:0] addr3 = {ext_addr, byte2, next_in};
  wire  [23:0] addr4 = {ext_addr, byte2, byte3};

  always_comb begin
    next_start = 1'b0;
    next_op    = isp_pkg::OP_NONE;
    next_addr  = addr4;
    next_wdata = next_in;
    if (done_b3 & armed & q_mem_rd) begin
      next_start = 1'b1;
      next_addr  = addr3;
      unique case (byte1)
        isp_pkg::SER_READ_HI: next_op = isp_pkg::OP_READ_HI;
        isp_pkg::SER_READ_LO: next_op = isp_pkg::OP_READ_LO;
        default: begin
          next_op   = isp_pkg::OP_EE_READ;
          next_addr = {8'h00, byte2, next_in};
        end
      endcase
    end else if (done_b4 & armed) begin
      next_start = 1'b1;
      unique case (byte1)
        isp_pkg::SER_PREFIX_AC: begin
          next_op    = isp_pkg::OP_CHIP_ERASE;
          next_start = byte2 == isp_pkg::SER_ERASE_B2;
        end
        isp_pkg::SER_LOAD_HI:    next_op = isp_pkg::OP_FLASH_HI;
        isp_pkg::SER_LOAD_LO:    next_op = isp_pkg::OP_FLASH_LO;
        isp_pkg::SER_FLASH_PAGE: next_op = isp_pkg::OP_FLASH_PAGE;
        isp_pkg::SER_EE_LOAD: begin
          next_op   = isp_pkg::OP_EE_LOAD;
          next_addr = {22'h000000, byte3[1:0]};
        end
        isp_pkg::SER_EE_PAGE: begin
          next_op   = isp_pkg::OP_EE_PAGE;
          next_addr = {8'h00, byte2, byte3};
        end
        isp_pkg::SER_EE_WRITE: begin
          next_op   = isp_pkg::OP_EE_WRITE;
          next_addr = {8'h00, byte2, byte3};
        end
        default: next_start = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      nvm_start <= 1'b0;
      nvm_op    <= isp_pkg::OP_NONE;
      nvm_addr  <= 24'h000000;
      nvm_wdata <= 8'h00;
    end else begin
      nvm_start <= next_start;
      if (next_start) begin
        nvm_op    <= next_op;
        nvm_addr  <= next_addr;
        nvm_wdata <= next_wdata;
      end
    end
  end

  // Frame counting; leaving reset drops the link and programming mode
  always_ff @(posedge clock) begin
    if (rst || !in_isp) begin
      bit_cnt          <= 5'h00;
      shift_in         <= 8'h00;
      serial_prog_mode <= 1'b0;
    end else begin
      if (s_rise) begin
        bit_cnt  <= bit_cnt + 5'h01;
        shift_in <= next_in;
      end
      if (done_b4 & cmd_en) serial_prog_mode <= 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      byte1    <= 8'h00;
      byte2    <= 8'h00;
      byte3    <= 8'h00;
      ext_addr <= 8'h00;
    end else begin
      if (byte_done & (bit_cnt[4:3] == 2'h0)) byte1 <= next_in;
      if (done_b2) byte2 <= next_in;
      if (done_b3) byte3 <= next_in;
      if (done_b4 & armed & (byte1 == isp_pkg::SER_EXT_ADDR)) ext_addr <= byte3;
    end
  end
  // Fuse and lock bytes are stored as written: zero means programmed
  wire fuse_wr = done_b4 & armed & is_ac;
  always_ff @(posedge clock) begin
    if (rst) begin
      fuse_low  <= isp_pkg::FUSE_RESET;
      fuse_high <= isp_pkg::FUSE_RESET;
      fuse_ext  <= isp_pkg::FUSE_RESET;
      lock_bits <= isp_pkg::FUSE_RESET;
    end else if (fuse_wr) begin
      if (byte2 == isp_pkg::SER_LOCK_WR_B2) lock_bits <= next_in;
      if (byte2 == isp_pkg::SER_FUSE_LO_B2) fuse_low <= next_in;
      if (byte2 == isp_pkg::SER_FUSE_HI_B2) fuse_high <= next_in;
      if (byte2 == isp_pkg::SER_FUSE_EX_B2) fuse_ext <= next_in;
    end
  end
  // Output byte: echo of the last byte, or the answer in the fourth slot
  always_ff @(posedge clock) begin
    if (rst) begin
      out_sr               <= 8'h00;
      rd_wait              <= 2'h0;
      serial_prog_data_out <= 1'b0;
    end else begin
      if (done_b3 & armed & q_local) out_sr <= local_reply;
      else if (done_b3 & armed & q_mem_rd) rd_wait <= isp_pkg::READ_LATENCY;
      else if (byte_done) out_sr <= next_in;
      else if (rd_wait == 2'h1) begin
        out_sr  <= nvm_rdata;
        rd_wait <= 2'h0;
      end else if (rd_wait != 2'h0) rd_wait <= rd_wait - 2'h1;
      if (s_fall) begin
        serial_prog_data_out <= out_sr[7];
        out_sr               <= {out_sr[6:0], 1'b0};
      end
    end
  end

  // JTAG disable bit, released while external reset is held low
  logic [1:0] jtd_cnt;
  always_ff @(posedge clock) begin
    if (rst) begin
      jtag_disable_bit <= 1'b0;
      jtd_cnt          <= 2'h0;
    end else if (jtd_write) begin
      jtag_disable_bit <= jtd_wdata;
      jtd_cnt          <= 2'h0;
    end else if (jtag_disable_bit & in_isp) begin
      jtd_cnt <= jtd_cnt + 2'h1;
      if (jtd_cnt == isp_pkg::JTD_CLEAR_CYCLES - 2'h1) begin
        jtag_disable_bit <= 1'b0;
      end
    end else begin
      jtd_cnt <= 2'h0;
    end
  end

  // TAP controller, stepped on each sampled TCK rise
  tap_state_type tap;
  tap_state_type tap_next;
  wire tap_on = jtag_enable_fuse & ~jtag_disable_bit;

  always_comb begin
    unique case (tap)
      TAP_RESET:     tap_next = tms_s ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:      tap_next = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR:    tap_next = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR:    tap_next = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR:  tap_next = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR:  tap_next = tms_s ? TAP_UPDATE_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR:  tap_next = tms_s ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR:  tap_next = tms_s ? TAP_UPDATE_DR : TAP_SHIFT_DR;
      TAP_UPDATE_DR: tap_next = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR:    tap_next = tms_s ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR:    tap_next = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR:  tap_next = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR:  tap_next = tms_s ? TAP_UPDATE_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR:  tap_next = tms_s ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR:  tap_next = tms_s ? TAP_UPDATE_IR : TAP_SHIFT_IR;
      TAP_UPDATE_IR: tap_next = tms_s ? TAP_SEL_DR : TAP_IDLE;
      default:       tap_next = TAP_RESET;
    endcase
  end

  logic [3:0]  ir;
  logic [3:0]  ir_sr;
  logic [15:0] dr;
  logic        reset_chain;

  wire sel_reset  = ir == isp_pkg::IR_CORE_RESET;
  wire sel_unlock = ir == isp_pkg::IR_PROG_UNLOCK;
  wire sel_cmd    = ir == isp_pkg::IR_PROG_COMMAND;
  wire step       = t_rise & tap_on;

  always_ff @(posedge clock) begin
    if (rst || !tap_on) begin
      tap <= TAP_RESET;
    end else if (t_rise) begin
      tap <= tap_next;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ir    <= isp_pkg::IR_BYPASS;
      ir_sr <= isp_pkg::IR_CAPTURE_VALUE;
    end else if (step) begin
      if (tap == TAP_RESET) ir <= isp_pkg::IR_BYPASS;
      if (tap == TAP_CAP_IR) ir_sr <= isp_pkg::IR_CAPTURE_VALUE;
      if (tap == TAP_SHIFT_IR) ir_sr <= {tdi_s, ir_sr[3:1]};
      if (tap == TAP_UPDATE_IR) ir <= ir_sr;
    end
  end
  // Unlock, command and bypass registers share one shifter, length set by the instruction; reset has its own bit
  always_ff @(posedge clock) begin
    if (rst) begin
      dr          <= 16'h0000;
      reset_chain <= 1'b0;
    end else if (step) begin
      if (tap == TAP_CAP_DR) dr <= sel_cmd ? {1'b0, jtag_cmd_result} : 16'h0000;
      if (tap == TAP_SHIFT_DR) begin
        if (sel_reset) reset_chain <= tdi_s;
        else if (sel_unlock) dr <= {tdi_s, dr[15:1]};
        else if (sel_cmd) dr <= {1'b0, tdi_s, dr[14:1]};
        else dr <= {15'h0000, tdi_s};
      end
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      jtag_prog_mode <= 1'b0;
      jtag_cmd       <= 15'h0000;
      jtag_cmd_clk   <= 1'b0;
    end else begin
      jtag_cmd_clk <= step & (tap == TAP_IDLE) & sel_cmd & jtag_prog_mode;
      if (!tap_on || (step && tap == TAP_RESET)) begin
        jtag_prog_mode <= 1'b0;
      end else if (step && tap == TAP_UPDATE_DR && sel_unlock) begin
        jtag_prog_mode <= dr == isp_pkg::UNLOCK_SIGNATURE;
      end
      if (step && tap == TAP_UPDATE_DR && sel_cmd && jtag_prog_mode) jtag_cmd <= dr[14:0];
    end
  end
  // TDO changes on the TCK fall so the far side samples it on the rise
  always_ff @(posedge clock) begin
    if (rst) begin
      tdo        <= 1'b0;
      core_reset <= 1'b0;
    end else begin
      core_reset <= in_isp | reset_chain;
      if (t_fall & tap_on & (tap == TAP_SHIFT_IR)) tdo <= ir_sr[0];
      else if (t_fall & tap_on & (tap == TAP_SHIFT_DR)) tdo <= sel_reset ? reset_chain : dr[0];
    end
  end

endmodule

//--- verilog/isp_pkg.sv
/*
 * Shared constants for the in-system programming command port: serial
 * instruction bytes, JTAG opcodes, the unlock signature, the operation
 * codes handed to the memory controller and the reset values.
 * Assumes one 200 MHz system clock; all pin timing is sampled against it.
 */
package isp_pkg;

  // Serial instruction bytes
  localparam logic [7:0] SER_PREFIX_AC   = 8'hac;
  localparam logic [7:0] SER_ENABLE_B2   = 8'h53;
  localparam logic [7:0] SER_ERASE_B2    = 8'h80;
  localparam logic [7:0] SER_LOCK_WR_B2  = 8'he0;
  localparam logic [7:0] SER_FUSE_LO_B2  = 8'ha0;
  localparam logic [7:0] SER_FUSE_HI_B2  = 8'ha8;
  localparam logic [7:0] SER_FUSE_EX_B2  = 8'ha4;
  localparam logic [7:0] SER_POLL        = 8'hf0;
  localparam logic [7:0] SER_EXT_ADDR    = 8'h4d;
  localparam logic [7:0] SER_LOAD_HI     = 8'h48;
  localparam logic [7:0] SER_LOAD_LO     = 8'h40;
  localparam logic [7:0] SER_EE_LOAD     = 8'hc1;
  localparam logic [7:0] SER_EE_PAGE     = 8'hc2;
  localparam logic [7:0] SER_EE_WRITE    = 8'hc0;
  localparam logic [7:0] SER_EE_READ     = 8'ha0;
  localparam logic [7:0] SER_READ_HI     = 8'h28;
  localparam logic [7:0] SER_READ_LO     = 8'h20;
  localparam logic [7:0] SER_FLASH_PAGE  = 8'h4c;
  localparam logic [7:0] SER_FUSE_RD_A   = 8'h50;
  localparam logic [7:0] SER_FUSE_RD_B   = 8'h58;
  localparam logic [7:0] SER_FUSE_SEL_0  = 8'h00;
  localparam logic [7:0] SER_FUSE_SEL_8  = 8'h08;

  // JTAG instruction register
  localparam int unsigned IR_WIDTH         = 4;
  localparam logic [3:0]  IR_CORE_RESET    = 4'hc;
  localparam logic [3:0]  IR_PROG_UNLOCK   = 4'h4;
  localparam logic [3:0]  IR_PROG_COMMAND  = 4'h5;
  localparam logic [3:0]  IR_BYPASS        = 4'hf;
  localparam logic [3:0]  IR_CAPTURE_VALUE = 4'h1;
  localparam int unsigned UNLOCK_WIDTH     = 16;
  localparam int unsigned COMMAND_WIDTH    = 15;
  localparam logic [15:0] UNLOCK_SIGNATURE = 16'ha370;

  // Memory controller operation codes
  localparam logic [3:0] OP_CHIP_ERASE  = 4'h1;
  localparam logic [3:0] OP_FLASH_LO    = 4'h2;
  localparam logic [3:0] OP_FLASH_HI    = 4'h3;
  localparam logic [3:0] OP_FLASH_PAGE  = 4'h4;
  localparam logic [3:0] OP_READ_LO     = 4'h5;
  localparam logic [3:0] OP_READ_HI     = 4'h6;
  localparam logic [3:0] OP_EE_LOAD     = 4'h7;
  localparam logic [3:0] OP_EE_PAGE     = 4'h8;
  localparam logic [3:0] OP_EE_WRITE    = 4'h9;
  localparam logic [3:0] OP_EE_READ     = 4'ha;
  localparam logic [3:0] OP_NONE        = 4'h0;

  // Counts and reset values
  localparam logic [1:0] JTD_CLEAR_CYCLES = 2'h2;
  localparam logic [1:0] READ_LATENCY     = 2'h2;
  localparam logic [7:0] FUSE_RESET       = 8'hff;
  localparam logic [5:0] SYNC_RESET       = 6'h00;

endpackage

//--- bench/isp_port_checker.sv
/* Port-level checker for the programming command port.
   Bound to the top module; sees only its ports. */
`timescale 1ns/1ps
module isp_port_checker (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        ext_reset_n,
  input wire logic        serial_clk,
  input wire logic        tck,
  input wire logic        serial_prog_data_out,
  input wire logic        tdo,
  input wire logic        jtag_disable_bit,
  input wire logic        core_reset,
  input wire logic        serial_prog_mode,
  input wire logic        jtag_prog_mode,
  input wire logic        nvm_start,
  input wire logic [3:0]  nvm_op,
  input wire logic [23:0] nvm_addr,
  input wire logic [14:0] jtag_cmd,
  input wire logic        jtag_cmd_clk
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Pins cross a two-stage synchroniser, so edges act a few clocks late
  sequence s_sclk_low;
    !$past(serial_clk, 2) || !$past(serial_clk, 3);
  endsequence
  sequence s_tck_low;
    !$past(tck, 2) || !$past(tck, 3);
  endsequence
  sequence s_tck_high;
    $past(tck, 2) || $past(tck, 3);
  endsequence
  sequence s_ext_low;
    !ext_reset_n [*5];
  endsequence
  property p_start_mode; nvm_start |-> serial_prog_mode; endproperty
  a_start_mode: assert property (p_start_mode) else $error("request outside mode");
  property p_start_pulse; nvm_start |=> !nvm_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("request too long");
  property p_req_held;
    !nvm_start && !$past(rst) |-> $stable(nvm_op) && $stable(nvm_addr);
  endproperty
  a_req_held: assert property (p_req_held) else $error("request moved");
  property p_sout_fall; $changed(serial_prog_data_out) |-> s_sclk_low; endproperty
  a_sout_fall: assert property (p_sout_fall) else $error("data out off fall");
  property p_tdo_fall; $changed(tdo) |-> s_tck_low; endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo off fall");
  property p_cmd_clk;
    jtag_cmd_clk |-> s_tck_high ##0 jtag_prog_mode ##1 !jtag_cmd_clk;
  endproperty
  a_cmd_clk: assert property (p_cmd_clk) else $error("bad command clock");
  property p_cmd_upd;
    $changed(jtag_cmd) && !$past(rst) |-> $past(jtag_prog_mode);
  endproperty
  a_cmd_upd: assert property (p_cmd_upd) else $error("command while locked");
  property p_jtd_clear; s_ext_low ##0 jtag_disable_bit |-> ##[0:4] !jtag_disable_bit; endproperty
  a_jtd_clear: assert property (p_jtd_clear) else $error("disable bit kept");
  property p_core_rst; s_ext_low |-> core_reset; endproperty
  a_core_rst: assert property (p_core_rst) else $error("core not in reset");
  property p_serial_off; ext_reset_n [*5] |-> !serial_prog_mode; endproperty
  a_serial_off: assert property (p_serial_off) else $error("serial mode kept");
endmodule

bind isp_programming_cmd_port isp_port_checker u_isp_port_checker (.clock, .rst,
  .ext_reset_n, .serial_clk, .tck, .serial_prog_data_out, .tdo, .jtag_disable_bit,
  .core_reset, .serial_prog_mode, .jtag_prog_mode, .nvm_start, .nvm_op, .nvm_addr,
  .jtag_cmd, .jtag_cmd_clk);

//--- bench/isp_nvm_model.sv
/* Memory controller model: read data two clocks after a read request,
   busy for a while after erase and page or byte writes. */
`timescale 1ns/1ps
module isp_nvm_model #(parameter int BUSY_CYCLES = 600) (
  input  wire logic        clock,
  input  wire logic        nvm_start,
  input  wire logic [3:0]  nvm_op,
  input  wire logic [23:0] nvm_addr,
  output logic             nvm_busy,
  output logic [7:0]       nvm_rdata
);
  int         busy_count = 0;
  logic [1:0] rd_pipe = 2'h0;
  logic [7:0] junk = 8'h00;
  wire is_read = nvm_op inside {isp_pkg::OP_READ_LO, isp_pkg::OP_READ_HI, isp_pkg::OP_EE_READ};
  wire is_slow = nvm_op inside {isp_pkg::OP_CHIP_ERASE, isp_pkg::OP_FLASH_PAGE,
                                isp_pkg::OP_EE_PAGE, isp_pkg::OP_EE_WRITE};
  wire [7:0] word = nvm_addr[7:0] ^ nvm_addr[15:8] ^ {8{nvm_op == isp_pkg::OP_READ_HI}};
  always_ff @(posedge clock) begin
    rd_pipe <= {rd_pipe[0], nvm_start && is_read};
    junk <= junk + 8'h3b;
    busy_count <= (nvm_start && is_slow) ? BUSY_CYCLES : (busy_count > 0 ? busy_count - 1 : 0);
  end
  assign nvm_busy = busy_count > 0;
  // Outside the answer slot the data wander, so a mistimed capture shows
  assign nvm_rdata = (rd_pipe != 2'h0) ? word : junk;
endmodule

//--- bench/isp_programming_cmd_port_bench.sv
/* Bench for the programming command port: acts as serial and JTAG
   programmer, with the memory controller model behind the block. */
`timescale 1ns/1ps
module isp_programming_cmd_port_bench;
  localparam int LIMIT = 40000;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        ext_reset_n = 1'b0;
  logic        serial_clk = 1'b0;
  logic        serial_prog_data_in = 1'b0;
  logic        tck = 1'b0;
  logic        tms = 1'b1;
  logic        tdi = 1'b0;
  logic        jtd_write = 1'b0;
  logic [14:0] jtag_cmd_result = 15'h0000;
  logic        serial_prog_data_out, tdo, jtag_disable_bit, core_reset, jtag_cmd_clk;
  logic        serial_prog_mode, jtag_prog_mode, nvm_start, nvm_busy;
  logic [3:0]  nvm_op, l_op;
  logic [23:0] nvm_addr, l_addr;
  logic [7:0]  nvm_wdata, nvm_rdata, l_wd, fuse_low, fuse_high, fuse_ext, lock_bits;
  logic [14:0] jtag_cmd;
  int          n_errors = 0, n_compared = 0, n_pulse = 0, cycles = 0;

  isp_programming_cmd_port u_isp_programming_cmd_port (.clock, .rst, .ext_reset_n,
    .serial_clk, .serial_prog_data_in, .serial_prog_data_out, .tck, .tms, .tdi, .tdo,
    .jtag_enable_fuse(1'b1), .jtd_write, .jtd_wdata(1'b1), .jtag_disable_bit, .core_reset,
    .serial_prog_mode, .jtag_prog_mode, .nvm_start, .nvm_op, .nvm_addr, .nvm_wdata,
    .nvm_busy, .nvm_rdata, .jtag_cmd, .jtag_cmd_clk, .jtag_cmd_result, .fuse_low,
    .fuse_high, .fuse_ext, .lock_bits);
  isp_nvm_model u_isp_nvm_model (.clock, .nvm_start, .nvm_op, .nvm_addr, .nvm_busy,
    .nvm_rdata);

  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (nvm_start) {l_op, l_addr, l_wd} <= {nvm_op, nvm_addr, nvm_wdata};
    if (jtag_cmd_clk) n_pulse++;
    if (cycles == LIMIT) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [39:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] exp_rd(input logic [15:0] a, input logic h);
    return a[7:0] ^ a[15:8] ^ {8{h}};
  endfunction
  // Pins change off the clock grid: the programmer is unrelated in phase
  task automatic ser(input logic [31:0] cmd, output logic [31:0] got);
    #1.3;
    for (int i = 31; i >= 0; i--) begin
      serial_clk = 1'b0;
      serial_prog_data_in = cmd[i];
      #32;
      got[i] = serial_prog_data_out;
      serial_clk = 1'b1;
      #32;
    end
    serial_clk = 1'b0;
    serial_prog_data_in = ~serial_prog_data_in;
  endtask
  task automatic wait_idle;
    logic [31:0] g;
    repeat (4) begin
      ser(32'hf0000000, g);
      if (g[0] === 1'b0) return;
    end
    chk("poll busy", g[0], 1'b0);
  endtask
  task automatic jstep(input logic m, d, output logic o);
    tck = 1'b0;
    tms = m;
    tdi = d;
    #32;
    o = tdo;
    tck = 1'b1;
    #32;
  endtask
  // From Run-Test/Idle through one IR or DR scan and back to Idle
  task automatic jscan(input logic ir, input int n, input logic [15:0] v,
                       output logic [15:0] got);
    logic o;
    got = 16'h0000;
    jstep(1'b1, 1'b0, o);
    if (ir) jstep(1'b1, 1'b0, o);
    jstep(1'b0, 1'b0, o);
    jstep(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      jstep(i == n - 1, v[i], o);
      got[i] = o;
    end
    jstep(1'b1, 1'b0, o);
    jstep(1'b0, 1'b0, o);
  endtask

  initial begin
    logic [31:0] g;
    logic [15:0] j, a;
    logic [7:0]  d;
    logic [7:0]  fv[4];
    logic        o;
    logic [7:0]  wb[4] = '{8'he0, 8'ha0, 8'ha8, 8'ha4};
    logic [15:0] rb[4] = '{16'h5800, 16'h5000, 16'h5808, 16'h5008};
    void'($urandom(27405));
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    repeat (6) @(posedge clock);
    chk("fuses", {lock_bits, fuse_low, fuse_high, fuse_ext}, 32'hffffffff);
    $display("reset test done");
    ser(32'hac530000, g);
    chk("enable echo", g[23:8], 16'hac53);
    chk("serial mode", serial_prog_mode, 1'b1);
    for (int k = 0; k < 4; k++) begin
      fv[k] = (k == 0) ? 8'h00 : 8'($urandom);
      ser({8'hac, wb[k], 8'h00, fv[k]}, g);
      ser({rb[k], 16'h0000}, g);
      chk("fuse read", g[7:0], fv[k]);
    end
    chk("fuse ports", {lock_bits, fuse_low, fuse_high, fuse_ext}, {fv[0], fv[1], fv[2], fv[3]});
    $display("fuse test done");
    ser(32'hac800000, g);
    chk("erase op", l_op, isp_pkg::OP_CHIP_ERASE);
    ser(32'hf0000000, g);
    chk("poll pending", g[7:0], 8'h01);
    wait_idle();
    $display("erase test done");
    a = 16'($urandom);
    d = 8'($urandom);
    ser({8'h4d, 8'h00, 8'h01, 8'h00}, g);
    ser({8'h40, 8'h00, a[7:0], d}, g);
    chk("load lo", {l_op, l_addr, l_wd}, {isp_pkg::OP_FLASH_LO, 16'h0100, a[7:0], d});
    ser({8'h48, 8'h00, a[7:0], ~d}, g);
    chk("load hi", {l_op, l_addr, l_wd}, {isp_pkg::OP_FLASH_HI, 16'h0100, a[7:0], ~d});
    ser({8'h4c, a, 8'h00}, g);
    chk("page write", {l_op, l_addr}, {isp_pkg::OP_FLASH_PAGE, 8'h01, a});
    wait_idle();
    for (int h = 0; h < 2; h++) begin
      ser({h ? 8'h28 : 8'h20, a, 8'h00}, g);
      chk("flash read", g[7:0], exp_rd(a, h[0]));
    end
    ser({8'hc1, 8'h00, 6'h00, a[1:0], d}, g);
    chk("ee load", {l_op, l_addr, l_wd}, {isp_pkg::OP_EE_LOAD, 22'h0, a[1:0], d});
    ser({8'hc2, 4'h0, a[11:2], 2'h0, 8'h00}, g);
    chk("ee page", {l_op, l_addr}, {isp_pkg::OP_EE_PAGE, 12'h000, a[11:2], 2'h0});
    wait_idle();
    $display("memory test done");
    @(posedge clock);
    jtd_write <= 1'b1;
    @(posedge clock);
    jtd_write <= 1'b0;
    repeat (8) @(posedge clock);
    chk("disable bit", jtag_disable_bit, 1'b0);
    ext_reset_n <= 1'b1;
    jtag_cmd_result <= 15'($urandom);
    #1.3;
    jstep(1'b0, 1'b0, o);
    jscan(1'b1, 4, 16'h0004, j);
    chk("ir capture", j[3:0], isp_pkg::IR_CAPTURE_VALUE);
    jscan(1'b0, 16, 16'ha371, j);
    chk("bad unlock", jtag_prog_mode, 1'b0);
    jscan(1'b0, 16, 16'ha370, j);
    chk("unlock", jtag_prog_mode, 1'b1);
    jscan(1'b1, 4, 16'h0005, j);
    jscan(1'b0, 15, 16'h2a5c, j);
    chk("command", jtag_cmd, 15'h2a5c);
    n_pulse = 0;
    repeat (3) jstep(1'b0, 1'b0, o);
    chk("cmd clocks", n_pulse, 3);
    jscan(1'b0, 15, 16'h0000, j);
    chk("result", j[14:0], jtag_cmd_result);
    jscan(1'b1, 4, 16'h000c, j);
    jscan(1'b0, 1, 16'h0001, j);
    chk("jtag reset", core_reset, 1'b1);
    jscan(1'b0, 1, 16'h0000, j);
    repeat (4) @(posedge clock);
    chk("jtag release", core_reset, 1'b0);
    $display("jtag test done");
    end_of_test();
  end
endmodule
